// ---- rtl/dac_control_pkg.sv ----
// Shared constants, types and carriers of the converter control block.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
package dac_control_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [3:0] CTRL_INDEX = 4'h0;
    localparam logic [3:0] VALUE_INDEX = 4'h2;
    localparam int ADR_WIDTH = 6;

    // Field positions.
    localparam int ENABLE_BIT = 0;
    localparam int BUFFER_BIT = 6;
    localparam int STANDBY_RUN_BIT = 7;
    localparam int LOW_FIELD_LSB = 6;
    localparam int HIGH_FIELD_LSB = 8;
    localparam int CODE_WIDTH = 10;

    // Values after reset.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;

    // Converter start-up after wake or enable.
    localparam int CLK_PERIOD_NS = 25;
    localparam int STARTUP_TIME_NS = 10000;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CONV_OFF = 2'b00,
        CONV_WARM = 2'b01,
        CONV_RUN = 2'b10
    } conv_state_t;

    // One register access, handed from the bus slave to the register file.
    typedef struct packed {
        logic wr;
        logic [3:0] index;
        logic [3:0] sel;
        logic [31:0] data;
    } reg_write_t;

    // Sleep request from the power manager, same clock domain.
    typedef struct packed {
        logic standby;
        logic power_down;
    } sleep_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } bus_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic done;
    } timer_state_t;

    typedef struct packed {
        conv_state_t st;
        logic [7:0] ctrl;
        logic [1:0] low;
        logic [7:0] high;
        logic [9:0] code;
        logic pend;
        logic start;
    } dac_state_t;

endpackage : dac_control_pkg

// ---- rtl/wb_reg_slave.sv ----
// Classic Wishbone slave front end: registered ack and read data.
// Assumes the master holds its request until it samples ack high.
module wb_reg_slave (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Wishbone
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [dac_control_pkg::ADR_WIDTH-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Register file side
    output dac_control_pkg::reg_write_t access_out,
    input wire logic [31:0] read_word_in
);
    import dac_control_pkg::*;

    bus_state_t cur_ff;
    bus_state_t nxt_cur;
    logic req;

    // Ack comes one cycle after the request and drops the cycle after.
    assign req = wb_cyc_in && wb_stb_in && !cur_ff.ack;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.ack = req;
        if (req) begin
            nxt_cur.rdata = wb_we_in ? 32'h0000_0000 : read_word_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // The write lands on the same edge at which the master samples ack.
    assign access_out.wr = wb_cyc_in && wb_stb_in && wb_we_in && cur_ff.ack;
    assign access_out.index = wb_adr_in[ADR_WIDTH-1:2];
    assign access_out.sel = wb_sel_in;
    assign access_out.data = wb_dat_in;
    assign wb_ack_out = cur_ff.ack;
    assign wb_dat_out = cur_ff.rdata;

endmodule : wb_reg_slave

// ---- rtl/startup_timer.sv ----
// Start-up delay counter for the converter.
// Assumes restart is a one-cycle pulse from the same clock domain.
module startup_timer #(
    parameter int CYCLES = dac_control_pkg::STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Control
    input wire logic restart_in,
    output logic done_out
);
    import dac_control_pkg::*;

    timer_state_t cur_ff;
    timer_state_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        if (restart_in) begin
            nxt_cur.count = 16'(CYCLES - 1);
            nxt_cur.done = 1'b0;
        end else if (cur_ff.count != 16'h0000) begin
            nxt_cur.count = cur_ff.count - 16'h0001;
        end else begin
            nxt_cur.done = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign done_out = cur_ff.done && !restart_in;

endmodule : startup_timer

// ---- rtl/dac_control_logic.sv ----
// Control logic of a 10-bit digital-to-analog converter.
// Assumes a Wishbone master on the system clock and a power manager that
// drives the sleep requests from the same clock domain.
//
// Overview of operation
// [R1] While enabled, every write of the data register starts a conversion; here only a write that includes the high byte does.
// [R2] While disabled, a data write starts nothing; the value converts once enable is set.
// [R3] Control bit 0 switches the converter on when 1 and off when 0.
// [R4] Control bit 6 routes the converter output through the buffer to the pin.
// [R5] With control bit 7 set, converter and buffer keep running in standby sleep.
// [R6] With bit 7 clear, standby sleep halts conversion and turns converter and buffer off.
// [R7] On leaving standby, converter and enabled buffer come back, then a start-up delay runs.
// [R8] In power-down sleep converter and buffer are always off.
// [R9] The code splits into bits 1:0 at the top of the low byte and bits 9:2 in the high byte.
// [R10] The output code changes only when the high data byte is written.
// [R11] The analog result is offered to internal peripherals whenever the converter is on.
// [R12] Software disables the pin's digital input in its pin configuration before use.
// [R13] Unimplemented and reserved bits read as zero and ignore writes.
//
// Design decision made here: the Wishbone interface to the registers.
module dac_control_logic #(
    parameter int CODE_BITS = dac_control_pkg::CODE_WIDTH,
    parameter int STARTUP = dac_control_pkg::STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Wishbone register bus
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [dac_control_pkg::ADR_WIDTH-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Sleep requests
    input dac_control_pkg::sleep_req_t sleep_in,
    // Analog core controls
    output logic converter_on_out,
    output logic pin_buffer_on_out,
    output logic internal_route_out,
    output logic [CODE_BITS-1:0] converter_code_out,
    output logic conversion_start_out,
    output logic startup_busy_out
);
    import dac_control_pkg::*;

    dac_state_t cur_ff;
    dac_state_t nxt_cur;
    reg_write_t access;
    logic [31:0] read_word;
    logic timer_done;
    logic timer_restart;
    logic allowed;
    logic ctrl_wr;
    logic low_wr;
    logic high_wr;
    logic [7:0] ctrl_next;

    // Decodes a byte-lane write to a given register.
    function automatic logic lane_write(
        input reg_write_t acc,
        input logic [3:0] index,
        input int lane
    );
        lane_write = acc.wr && (acc.index == index) && acc.sel[lane];
    endfunction : lane_write

    wb_reg_slave u_bus (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out),
        .access_out(access),
        .read_word_in(read_word)
    );

    startup_timer #(
        .CYCLES(STARTUP)
    ) u_timer (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .restart_in(timer_restart),
        .done_out(timer_done)
    );

    // Register strobes.
    assign ctrl_wr = lane_write(access, CTRL_INDEX, 0);
    assign low_wr = lane_write(access, VALUE_INDEX, 0);
    assign high_wr = lane_write(access, VALUE_INDEX, 1);

    // Only the three implemented control bits are stored.
    always_comb begin
        ctrl_next = 8'h00;
        ctrl_next[ENABLE_BIT] = access.data[ENABLE_BIT];
        ctrl_next[BUFFER_BIT] = access.data[BUFFER_BIT];
        ctrl_next[STANDBY_RUN_BIT] = access.data[STANDBY_RUN_BIT];
    end

    // The converter may run only when enabled and no sleep mode forbids it.
    always_comb begin
        allowed = cur_ff.ctrl[ENABLE_BIT]; // [R3]
        if (sleep_in.power_down) begin
            allowed = 1'b0; // [R8]
        end else if (sleep_in.standby && !cur_ff.ctrl[STANDBY_RUN_BIT]) begin // [R5]
            allowed = 1'b0; // [R6]
        end
    end

    // Restart the start-up delay whenever the converter is switched back on.
    assign timer_restart = allowed && (cur_ff.st == CONV_OFF); // [R7]

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.start = 1'b0;

        if (ctrl_wr) begin
            nxt_cur.ctrl = ctrl_next; // [R13]
            // A value written while disabled converts once enabled again.
            if (ctrl_next[ENABLE_BIT] && !cur_ff.ctrl[ENABLE_BIT]) begin
                nxt_cur.pend = 1'b1; // [R2]
            end
        end

        if (low_wr) begin
            // The low byte is only staged; the output waits for the high byte.
            nxt_cur.low = access.data[LOW_FIELD_LSB +: 2]; // [R9]
        end

        if (high_wr) begin
            nxt_cur.high = access.data[HIGH_FIELD_LSB +: 8]; // [R9]
            nxt_cur.code = {access.data[HIGH_FIELD_LSB +: 8], nxt_cur.low}; // [R10]
        end

        case (cur_ff.st)
            CONV_OFF: begin
                if (allowed) begin
                    nxt_cur.st = CONV_WARM; // [R7]
                end
            end
            CONV_WARM: begin
                if (!allowed) begin
                    nxt_cur.st = CONV_OFF; // [R6]
                end else if (timer_done) begin
                    nxt_cur.st = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (!allowed) begin
                    nxt_cur.st = CONV_OFF; // [R6]
                end else if (cur_ff.pend) begin
                    nxt_cur.start = 1'b1; // [R1]
                    nxt_cur.pend = 1'b0;
                end
            end
            default: begin
                nxt_cur.st = CONV_OFF;
            end
        endcase

        // A data write in the same cycle as a start still leaves a start queued.
        if (high_wr) begin
            nxt_cur.pend = 1'b1; // [R1]
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cur_ff.st <= CONV_OFF;
            cur_ff.ctrl <= CTRL_RESET;
            cur_ff.low <= VALUE_RESET[LOW_FIELD_LSB +: 2];
            cur_ff.high <= VALUE_RESET[HIGH_FIELD_LSB +: 8];
            cur_ff.code <= VALUE_RESET[LOW_FIELD_LSB +: 10];
            cur_ff.pend <= 1'b0;
            cur_ff.start <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Read mux; unmapped words and reserved bits read as zero.
    always_comb begin
        read_word = 32'h0000_0000;
        if (access.index == CTRL_INDEX) begin
            read_word[7:0] = cur_ff.ctrl; // [R13]
        end else if (access.index == VALUE_INDEX) begin
            read_word[LOW_FIELD_LSB +: 2] = cur_ff.low; // [R9]
            read_word[HIGH_FIELD_LSB +: 8] = cur_ff.high;
        end
    end

    // Power is removed in sleep as soon as the request arrives, so the
    // analog core never sees a stale enable for a cycle.
    assign converter_on_out = (cur_ff.st != CONV_OFF) && allowed; // [R6]
    assign pin_buffer_on_out = converter_on_out && cur_ff.ctrl[BUFFER_BIT]; // [R4]
    // Internal users need only the converter, not the pin buffer.
    assign internal_route_out = converter_on_out; // [R11]
    assign converter_code_out = cur_ff.code;
    assign conversion_start_out = cur_ff.start;
    assign startup_busy_out = (cur_ff.st == CONV_WARM);

endmodule : dac_control_logic

// ---- testbench/dac_control_chk.sv ----
// Port checker of the converter control block.
// Assumes it is bound into dac_control_logic and sees only its ports.
module dac_control_chk #(
    parameter int CODE_BITS = 10,
    parameter int STARTUP = 400
) (
    // Clock, reset and bus
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [5:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic wb_ack_out,
    // Sleep and analog controls
    input wire dac_control_pkg::sleep_req_t sleep_in,
    input wire logic converter_on_out,
    input wire logic pin_buffer_on_out,
    input wire logic internal_route_out,
    input wire logic [CODE_BITS-1:0] converter_code_out,
    input wire logic conversion_start_out,
    input wire logic startup_busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import dac_control_pkg::*;
    // The start-up delay spans the timer load cycle plus STARTUP counted cycles.
    localparam int WARM_MAX = STARTUP + 1;
    int warm_cnt_ff;
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            warm_cnt_ff <= 0;
        end else begin
            warm_cnt_ff <= startup_busy_out ? warm_cnt_ff + 1 : 0;
        end
    end
    wire value_wr = wb_ack_out && wb_we_in && wb_sel_in[1] && (wb_adr_in[5:2] == VALUE_INDEX);
    wire off_wr = wb_ack_out && wb_we_in && wb_sel_in[0] && !wb_dat_in[0] && wb_adr_in[5:2] == 0;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    sequence s_warm_done;
        ##[1:WARM_MAX] !startup_busy_out;
    endsequence
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not acknowledged");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    a_down_off: assert property (sleep_in.power_down |-> !converter_on_out)
        else $error("converter on in power-down");
    a_route_same: assert property (internal_route_out == converter_on_out)
        else $error("internal route differs from converter power");
    a_buf_conv: assert property (pin_buffer_on_out |-> converter_on_out)
        else $error("pin buffer on without converter");
    a_start_ready: assert property (conversion_start_out |-> !startup_busy_out ##1 !conversion_start_out)
        else $error("start pulse during start-up or too long");
    a_code_hold: assert property ($changed(converter_code_out) |-> $past(value_wr))
        else $error("code changed without high byte write");
    a_off_write: assert property (off_wr |-> ##[1:2] !converter_on_out)
        else $error("converter stays on after disable");
    a_warm_bound: assert property ($rose(startup_busy_out) |-> s_warm_done)
        else $error("start-up delay does not end");
    a_warm_full: assert property ($fell(startup_busy_out) && converter_on_out |-> warm_cnt_ff == WARM_MAX)
        else $error("start-up delay ended early");
endmodule : dac_control_chk

bind dac_control_logic dac_control_chk #(.CODE_BITS(CODE_BITS), .STARTUP(STARTUP)) u_chk (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
    .sleep_in(sleep_in), .converter_on_out(converter_on_out),
    .pin_buffer_on_out(pin_buffer_on_out), .internal_route_out(internal_route_out),
    .converter_code_out(converter_code_out), .conversion_start_out(conversion_start_out),
    .startup_busy_out(startup_busy_out));

// ---- testbench/tb_top.sv ----
// Self-checking bench of the converter control block.
// Assumes the checker is bound in; the start-up count is cut to SU cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dac_control_pkg::*;
    localparam int SU = 4;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [5:0] wb_adr = 6'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0, rd, rnd = 32'hB7CB583D;
    logic [7:0] hi, lo;
    sleep_req_t sleep = 2'b00;
    wire [31:0] wb_dat_out;
    wire ack, on, buf_on, route, start, busy;
    wire [9:0] code;
    int n_mismatch = 0, checked = 0, n_start = 0, cycles = 0, j;
    always #12.5 clk_sys_in = ~clk_sys_in;
    dac_control_logic #(.STARTUP(SU)) DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(ack),
        .sleep_in(sleep), .converter_on_out(on), .pin_buffer_on_out(buf_on),
        .internal_route_out(route), .converter_code_out(code),
        .conversion_start_out(start), .startup_busy_out(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Holds the request until ack is sampled, then idles one cycle.
    // No wait limit of its own: a request that is never answered runs into the cycle ceiling.
    task bus(input logic w, input logic [3:0] idx, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_sys_in);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, w, idx, 2'b00, s, d};
        do begin
            @(posedge clk_sys_in);
        end while (ack !== 1'b1);
        rd = wb_dat_out;
        {wb_cyc, wb_stb} <= 2'b00;
        @(posedge clk_sys_in);
    endtask : bus
    task settle;
        repeat (SU + 8) @(posedge clk_sys_in);
    endtask : settle
    always @(posedge clk_sys_in) begin
        cycles++;
        if (start === 1'b1) n_start++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        bus(0, CTRL_INDEX, 4'hF, 0); check(rd, {24'h0, CTRL_RESET});
        bus(0, VALUE_INDEX, 4'hF, 0); check(rd, {16'h0, VALUE_RESET});
        repeat (4) begin
            rnd = lfsr(rnd);
            bus(1, CTRL_INDEX, 4'h1, rnd & 32'hFFFFFFFE);
            bus(0, CTRL_INDEX, 4'hF, 0); check(rd, {24'h0, rnd[7:6], 6'h00});
        end
        bus(1, 4'h5, 4'hF, rnd); bus(0, 4'h5, 4'hF, 0); check(rd, 0);
        bus(1, CTRL_INDEX, 4'h1, 0);
        $display("test registers done");
        rnd = lfsr(rnd); hi = rnd[15:8]; lo = rnd[7:0];
        bus(1, VALUE_INDEX, 4'h3, rnd); settle; check(n_start, 0);
        check(code, {hi, lo[7:6]});
        bus(0, VALUE_INDEX, 4'hF, 0); check(rd, {hi, lo[7:6], 6'h00});
        lo = ~rnd[7:0];
        bus(1, VALUE_INDEX, 4'h1, ~rnd); check(code, {hi, rnd[7:6]});
        bus(1, CTRL_INDEX, 4'h1, 1); settle; check(n_start, 1);
        check({on, route, buf_on}, 3'b110);
        rnd = lfsr(rnd); hi = rnd[15:8];
        bus(1, VALUE_INDEX, 4'h2, rnd); settle; check(n_start, 2);
        check(code, {hi, lo[7:6]});
        $display("test conversion done");
        // The pin's digital input is taken as disabled before the buffer is turned on.
        bus(1, CTRL_INDEX, 4'h1, 32'h41); settle; check(buf_on, 1);
        sleep <= 2'b10; repeat (2) @(posedge clk_sys_in);
        check({on, buf_on}, 2'b00);
        sleep <= 2'b00; j = 0;
        while (busy !== 1'b1 && j < 20) begin
            @(posedge clk_sys_in);
            j++;
        end
        check(busy, 1); settle; check({on, buf_on, busy}, 3'b110);
        bus(1, CTRL_INDEX, 4'h1, 32'hC1);
        sleep <= 2'b10; repeat (2) @(posedge clk_sys_in);
        check({on, buf_on}, 2'b11);
        sleep <= 2'b01; repeat (2) @(posedge clk_sys_in);
        check({on, buf_on}, 2'b00);
        sleep <= 2'b00; settle;
        bus(1, CTRL_INDEX, 4'h1, 0); settle; check(on, 0);
        $display("test sleep done");
        give_verdict();
    end
endmodule : tb_top
